// >>> logic/erqf_pkg.sv
// receive queue / frame filter control: register map, field positions, reset values, carrier types
// assumes a byte-wide host register port and a byte stream from the mac receiver on the same clock
package erqf_pkg;
    // host register offsets
    localparam logic [9:0] OFS_HIGH_MARK   = 10'h15b;
    localparam logic [9:0] OFS_IRQ_ENABLES = 10'h15c;
    localparam logic [9:0] OFS_FLAGS       = 10'h15d;
    localparam logic [9:0] OFS_REJECT_CTL  = 10'h15e;
    localparam logic [9:0] OFS_MAC_RD_HI   = 10'h140;
    localparam logic [9:0] OFS_MAC_RD_LO   = 10'h141;
    localparam logic [9:0] OFS_MAC_WR_HI   = 10'h142;
    localparam logic [9:0] OFS_MAC_WR_LO   = 10'h143;
    localparam logic [9:0] OFS_MAC_RD_DATA = 10'h144;
    localparam logic [9:0] OFS_MAC_WR_DATA = 10'h145;
    // indirect address of the mac control word, bytes msb first
    localparam logic [15:0] IND_MAC_CTL    = 16'h0000;
    localparam logic [15:0] IND_MAC_CTL_HI = 16'h0003;
    // mac control word fields
    localparam int          BIT_HEARTBEAT_OFF  = 28;
    localparam int          BIT_PORT_SELECT    = 27;
    localparam int          BIT_FORWARD_ALL    = 19;
    localparam int          BIT_TX_ENABLE      = 3;
    localparam int          BIT_RX_ENABLE      = 2;
    localparam logic [31:0] MAC_CTL_RESET      = 32'h0008_0000;
    localparam logic [31:0] MAC_CTL_WRITABLE   = 32'h18bc_15ec;
    // status flag and enable positions (high and low are swapped between them)
    localparam int FLG_FIFO_OVF  = 3;
    localparam int FLG_QUEUE_OVF = 2;
    localparam int FLG_HIGH      = 1;
    localparam int FLG_LOW       = 0;
    localparam int IEN_FIFO_OVF  = 3;
    localparam int IEN_QUEUE_OVF = 2;
    localparam int IEN_LOW       = 1;
    localparam int IEN_HIGH      = 0;
    // reject control fields
    localparam int REJ_NONPAUSE = 6;
    localparam int REJ_CTL      = 5;
    localparam int REJ_LEN      = 4;
    localparam int REJ_FCS      = 3;
    localparam int REJ_ODD      = 2;
    localparam int REJ_PHY      = 1;
    localparam int REJ_BCAST    = 0;
    localparam logic [7:0] REG8_RESET  = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    // queue geometry: mark unit is 32 buffers of 2048 bytes
    localparam int          MARK_SHIFT = 16;
    localparam int          QCNT_W     = 24;
    localparam logic [23:0] QCNT_MAX   = 24'hff_ffff;
    localparam int          FIFO_DEPTH = 32;
    localparam int          FIFO_WIDTH = 9;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } erqf_byte_t;

    typedef struct packed {
        logic bcast;
        logic ctl_frame;
        logic unsup_ctl;
        logic len_err;
        logic crc_err;
        logic mii_err;
        logic dribble;
        logic runt;
        logic collided;
    } erqf_frame_stat_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [7:0]  wdata;
    } erqf_host_req_t;
endpackage

// >>> logic/erqf_rx_ctrl.sv
// receive-side queue watermarks, latched flags, frame filter and indirect mac control word
// assumes host strobes and mac stream are synchronous to core_clk_in
`timescale 1ns/10ps

module erqf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             commit_in,
    input  wire logic             drop_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    cm_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    next_wr;
    logic [PW-1:0]    next_cm;
    logic [PW-1:0]    next_rd;
    logic             push;
    logic             pop;

    // entries become readable only once their frame is committed
    assign out_valid_out = (cm_ptr != rd_ptr);
    assign out_data_out  = mem[rd_ptr[PW-2:0]];
    assign push          = in_valid_in && in_ready_out && !drop_in;
    assign pop           = out_valid_out && out_ready_in;

    always_comb
    begin
        next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_wr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_cm = cm_ptr;
        if (drop_in)
        begin
            next_wr = cm_ptr;
        end
        else if (commit_in)
        begin
            next_cm = next_wr;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr[PW-2:0]] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr       <= '0;
            cm_ptr       <= '0;
            rd_ptr       <= '0;
            in_ready_out <= 1'b0;
        end
        else
        begin
            wr_ptr       <= next_wr;
            cm_ptr       <= next_cm;
            rd_ptr       <= next_rd;
            in_ready_out <= ((next_wr - next_rd) != DEPTH_P);
        end
    end
endmodule // erqf_fifo

module erqf_rx_ctrl
    import erqf_pkg::*;
(
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire erqf_pkg::erqf_host_req_t  host_req_in,
    output logic [7:0]                     host_rdata_out,
    input  wire logic                      rx_valid_in,
    input  wire erqf_pkg::erqf_byte_t      rx_byte_in,
    input  wire erqf_pkg::erqf_frame_stat_t rx_stat_in,
    output logic                           rx_ready_out,
    output logic                           q_valid_out,
    output erqf_pkg::erqf_byte_t           q_byte_out,
    input  wire logic                      q_ready_in,
    input  wire logic                      q_drain_in,
    input  wire logic [7:0]                low_mark_in,
    output logic                           irq_out,
    output logic [31:0]                    mac_ctl_word_out,
    output logic                           heartbeat_off_out,
    output logic                           forward_all_frames_out,
    output logic                           tx_enable_bit_out,
    output logic                           rx_enable_bit_out
);
    import erqf_pkg::*;

    function automatic logic [QCNT_W-1:0] mark_bytes(input logic [7:0] v);
        mark_bytes = {v, 16'h0000};
    endfunction

    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [15:0] a);
        case (a[1:0])
            2'h0:    word_byte = w[31:24];
            2'h1:    word_byte = w[23:16];
            2'h2:    word_byte = w[15:8];
            default: word_byte = w[7:0];
        endcase
    endfunction

    logic [7:0]        queue_high_mark;
    logic [3:0]        queue_irq_enables;
    logic [3:0]        queue_latched_flags;
    logic [6:0]        frame_reject_ctl;
    logic [31:0]       mac_ctl_word;
    logic [15:0]       mac_read_addr;
    logic [15:0]       mac_write_addr;
    logic [QCNT_W-1:0] q_fill;
    logic [QCNT_W-1:0] next_fill;
    logic              frame_bad;
    logic              reject;
    logic              fifo_ready;
    logic              fifo_valid;
    erqf_byte_t        fifo_byte;
    logic              fifo_pop;
    logic              fifo_drop;
    logic              fifo_commit;
    logic              take;
    logic              q_push;
    logic              q_ovf;
    logic              hi_cross;
    logic              lo_cross;
    logic              flags_read;
    logic [3:0]        flag_set;
    logic [7:0]        next_rdata;

    // host writes to plain registers
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            queue_high_mark   <= REG8_RESET;
            queue_irq_enables <= REG8_RESET[3:0];
            frame_reject_ctl  <= REG8_RESET[6:0];
            mac_read_addr     <= 16'h0000;
            mac_write_addr    <= 16'h0000;
        end
        else if (host_req_in.wr)
        begin
            case (host_req_in.addr)
                OFS_HIGH_MARK:   queue_high_mark         <= host_req_in.wdata;
                OFS_IRQ_ENABLES: queue_irq_enables       <= host_req_in.wdata[3:0];
                OFS_REJECT_CTL:  frame_reject_ctl        <= host_req_in.wdata[6:0];
                OFS_MAC_RD_HI:   mac_read_addr[15:8]     <= host_req_in.wdata;
                OFS_MAC_RD_LO:   mac_read_addr[7:0]      <= host_req_in.wdata;
                OFS_MAC_WR_HI:   mac_write_addr[15:8]    <= host_req_in.wdata;
                OFS_MAC_WR_LO:   mac_write_addr[7:0]     <= host_req_in.wdata;
                default:         ;
            endcase
        end
    end

    // indirect mac control word; reserved bits stay at zero
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mac_ctl_word <= MAC_CTL_RESET;
        end
        else if (host_req_in.wr && host_req_in.addr == OFS_MAC_WR_DATA
                 && mac_write_addr <= IND_MAC_CTL_HI)
        begin
            case (mac_write_addr[1:0])
                2'h0:    mac_ctl_word[31:24] <= host_req_in.wdata & MAC_CTL_WRITABLE[31:24];
                2'h1:    mac_ctl_word[23:16] <= host_req_in.wdata & MAC_CTL_WRITABLE[23:16];
                2'h2:    mac_ctl_word[15:8]  <= host_req_in.wdata & MAC_CTL_WRITABLE[15:8];
                default: mac_ctl_word[7:0]   <= host_req_in.wdata & MAC_CTL_WRITABLE[7:0];
            endcase
        end
    end

    // port select is left to software; the block only carries the stored value
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mac_ctl_word_out       <= MAC_CTL_RESET;
            heartbeat_off_out      <= MAC_CTL_RESET[BIT_HEARTBEAT_OFF];
            forward_all_frames_out <= MAC_CTL_RESET[BIT_FORWARD_ALL];
            tx_enable_bit_out      <= MAC_CTL_RESET[BIT_TX_ENABLE];
            rx_enable_bit_out      <= MAC_CTL_RESET[BIT_RX_ENABLE];
        end
        else
        begin
            mac_ctl_word_out       <= mac_ctl_word;
            heartbeat_off_out      <= mac_ctl_word[BIT_HEARTBEAT_OFF];
            forward_all_frames_out <= mac_ctl_word[BIT_FORWARD_ALL];
            tx_enable_bit_out      <= mac_ctl_word[BIT_TX_ENABLE];
            rx_enable_bit_out      <= mac_ctl_word[BIT_RX_ENABLE];
        end
    end

    // frame filter, evaluated with the status that rides on the last byte
    always_comb
    begin
        reject = 1'b0;
        if (rx_stat_in.ctl_frame && !frame_reject_ctl[REJ_CTL])
            reject = 1'b1;
        if (rx_stat_in.ctl_frame && rx_stat_in.unsup_ctl && !frame_reject_ctl[REJ_NONPAUSE])
            reject = 1'b1;
        if (rx_stat_in.len_err && !frame_reject_ctl[REJ_LEN])
            reject = 1'b1;
        if ((rx_stat_in.crc_err || rx_stat_in.mii_err) && !frame_reject_ctl[REJ_FCS])
            reject = 1'b1;
        if (rx_stat_in.dribble && !rx_stat_in.runt && !rx_stat_in.collided && !frame_reject_ctl[REJ_ODD])
            reject = 1'b1;
        if (rx_stat_in.mii_err && !frame_reject_ctl[REJ_PHY])
            reject = 1'b1;
        if (rx_stat_in.bcast && !frame_reject_ctl[REJ_BCAST])
            reject = 1'b1;
    end

    // the mac cannot stall: a byte offered while full is lost and spoils its frame
    assign take        = rx_valid_in && rx_enable_bit_out;
    assign fifo_drop   = take && rx_byte_in.last && (reject || frame_bad || !fifo_ready);
    assign fifo_commit = take && rx_byte_in.last && !fifo_drop;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            frame_bad <= 1'b0;
        end
        else if (take && rx_byte_in.last)
        begin
            frame_bad <= 1'b0;
        end
        else if (take && !fifo_ready)
        begin
            frame_bad <= 1'b1;
        end
    end

    erqf_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (take),
        .in_ready_out  (fifo_ready),
        .in_data_in    (rx_byte_in),
        .commit_in     (fifo_commit),
        .drop_in       (fifo_drop),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_byte)
    );

    assign rx_ready_out = fifo_ready;

    // output stage toward the serial-side queue in memory
    assign fifo_pop = fifo_valid && (!q_valid_out || q_ready_in);
    assign q_push   = q_valid_out && q_ready_in;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_valid_out <= 1'b0;
            q_byte_out  <= '0;
        end
        else if (!q_valid_out || q_ready_in)
        begin
            q_valid_out <= fifo_valid;
            q_byte_out  <= fifo_byte;
        end
    end

    // queue fill in bytes: ethernet data waiting for the serial side
    assign q_ovf = q_push && (q_fill == QCNT_MAX) && !q_drain_in;

    always_comb
    begin
        next_fill = q_fill;
        if (q_push && !q_drain_in && !q_ovf)
            next_fill = q_fill + 1'b1;
        else if (q_drain_in && !q_push && q_fill != '0)
            next_fill = q_fill - 1'b1;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_fill <= '0;
        end
        else
        begin
            q_fill <= next_fill;
        end
    end

    assign hi_cross = (q_fill < mark_bytes(queue_high_mark))
                      && (next_fill >= mark_bytes(queue_high_mark));
    assign lo_cross = (q_fill >= mark_bytes(low_mark_in)) && (next_fill < mark_bytes(low_mark_in));

    always_comb
    begin
        flag_set                = 4'h0;
        flag_set[FLG_FIFO_OVF]  = take && !fifo_ready;
        flag_set[FLG_QUEUE_OVF] = q_ovf;
        flag_set[FLG_HIGH]      = hi_cross;
        flag_set[FLG_LOW]       = lo_cross;
    end

    // clear on read; an event in the reading cycle survives the clear
    assign flags_read = host_req_in.rd && host_req_in.addr == OFS_FLAGS;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            queue_latched_flags <= FLAGS_RESET;
        end
        else
        begin
            queue_latched_flags <= (flags_read ? 4'h0 : queue_latched_flags) | flag_set;
        end
    end

    // interrupt level, with the high and low enables swapped against the flags
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= (queue_latched_flags[FLG_FIFO_OVF] && queue_irq_enables[IEN_FIFO_OVF])
                    || (queue_latched_flags[FLG_QUEUE_OVF] && queue_irq_enables[IEN_QUEUE_OVF])
                    || (queue_latched_flags[FLG_LOW] && queue_irq_enables[IEN_LOW])
                    || (queue_latched_flags[FLG_HIGH] && queue_irq_enables[IEN_HIGH]);
        end
    end

    // read data, unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        case (host_req_in.addr)
            OFS_HIGH_MARK:   next_rdata = queue_high_mark;
            OFS_IRQ_ENABLES: next_rdata = {4'h0, queue_irq_enables};
            OFS_FLAGS:       next_rdata = {4'h0, queue_latched_flags};
            OFS_REJECT_CTL:  next_rdata = {1'b0, frame_reject_ctl};
            OFS_MAC_RD_HI:   next_rdata = mac_read_addr[15:8];
            OFS_MAC_RD_LO:   next_rdata = mac_read_addr[7:0];
            OFS_MAC_WR_HI:   next_rdata = mac_write_addr[15:8];
            OFS_MAC_WR_LO:   next_rdata = mac_write_addr[7:0];
            OFS_MAC_RD_DATA:
                if (mac_read_addr <= IND_MAC_CTL_HI)
                    next_rdata = word_byte(mac_ctl_word, mac_read_addr);
            default:         next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            host_rdata_out <= 8'h00;
        end
        else if (host_req_in.rd)
        begin
            host_rdata_out <= next_rdata;
        end
    end
endmodule // erqf_rx_ctrl

// >>> bench/erqf_rx_ctrl_assertions.sv
// checker for erqf_rx_ctrl: port-level relations of host reads, mac word copies, queue stream and interrupt
// assumes one clock domain and the async active-high reset of the design
`timescale 1ns/10ps

module erqf_rx_ctrl_assertions
    import erqf_pkg::*;
(
    input wire logic                       core_clk_in,
    input wire logic                       rst_in,
    input wire erqf_pkg::erqf_host_req_t   host_req_in,
    input wire logic [7:0]                 host_rdata_out,
    input wire logic                       q_valid_out,
    input wire erqf_pkg::erqf_byte_t       q_byte_out,
    input wire logic                       q_ready_in,
    input wire logic                       irq_out,
    input wire logic [31:0]                mac_ctl_word_out,
    input wire logic                       heartbeat_off_out,
    input wire logic                       forward_all_frames_out,
    input wire logic                       tx_enable_bit_out,
    input wire logic                       rx_enable_bit_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    hb_copy_a: assert property (heartbeat_off_out == mac_ctl_word_out[BIT_HEARTBEAT_OFF])
        else $error("heartbeat off output differs from mac word");
    fwd_copy_a: assert property (forward_all_frames_out == mac_ctl_word_out[BIT_FORWARD_ALL])
        else $error("forward all output differs from mac word");
    txrx_copy_a: assert property ({tx_enable_bit_out, rx_enable_bit_out} == mac_ctl_word_out[3:2])
        else $error("enable outputs differ from mac word");
    reserved_zero_a: assert property ((mac_ctl_word_out & ~MAC_CTL_WRITABLE) == 32'h0)
        else $error("reserved mac bit set");
    rdata_hold_a: assert property (!host_req_in.rd |=> $stable(host_rdata_out))
        else $error("read data changed without a read");
    unmapped_rd_a: assert property (host_req_in.rd && host_req_in.addr == 10'h3ff |=> host_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    flag_upper_a: assert property (host_req_in.rd && host_req_in.addr == OFS_FLAGS |=> host_rdata_out[7:4] == 4'h0)
        else $error("flag read upper bits set");
    q_hold_a: assert property (q_valid_out && !q_ready_in |=> q_valid_out && $stable(q_byte_out))
        else $error("queue byte dropped while stalled");
    irq_mask_a: assert property (host_req_in.wr && host_req_in.addr == OFS_IRQ_ENABLES && host_req_in.wdata == 8'h00
        |-> ##[1:3] !irq_out)
        else $error("interrupt stays with all enables clear");
endmodule // erqf_rx_ctrl_assertions

bind erqf_rx_ctrl erqf_rx_ctrl_assertions u_erqf_rx_ctrl_assertions (.core_clk_in, .rst_in, .host_req_in,
    .host_rdata_out, .q_valid_out, .q_byte_out, .q_ready_in, .irq_out, .mac_ctl_word_out, .heartbeat_off_out,
    .forward_all_frames_out, .tx_enable_bit_out, .rx_enable_bit_out);

// >>> bench/erqf_q_sink.sv
// serial-side queue writer model: accepts bytes with random stalls, drains each one a cycle later
// assumes the stream holds its byte until ready; stall_in forces ready low
`timescale 1ns/10ps

module erqf_q_sink (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic q_valid_in,
    input wire logic stall_in,
    output logic     q_ready_out,
    output logic     q_drain_out
);
    logic hs;

    initial
    begin
        q_ready_out = 1'b0;
        q_drain_out = 1'b0;
    end

    // every accepted byte leaves for the serial side on the next cycle
    always @(posedge core_clk_in)
    begin
        hs = q_valid_in && q_ready_out;
        #1;
        q_drain_out = hs && !rst_in;
        q_ready_out = !rst_in && !stall_in && ($urandom_range(3) != 0);
    end
endmodule // erqf_q_sink

// >>> bench/tb.sv
// testbench for erqf_rx_ctrl: registers, indirect mac word, frame filter, fifo overflow and interrupt
// assumes the q sink model on the queue side; inputs change 1 ns after the rising edge
`timescale 1ns/10ps

module tb;
    import erqf_pkg::*;
    logic             core_clk_in = 1'b0;
    logic             rst_in = 1'b1;
    erqf_host_req_t   host_req = '0;
    logic [7:0]       host_rdata;
    logic             rx_valid = 1'b0;
    erqf_byte_t       rx_byte = '0;
    erqf_frame_stat_t rx_stat = '0;
    logic             rx_ready, q_valid, q_ready, q_drain, irq, hb_off, fwd_all, tx_en, rx_en;
    logic             stall = 1'b0;
    erqf_byte_t       q_byte;
    logic [31:0]      mac_word;
    int               n_errors = 0;
    int               checks_done = 0;
    int               cycles = 0;
    logic [7:0]       rdq[$];
    erqf_byte_t       eq[$];
    logic [7:0]       v;
    // stat, accepting control, rejecting control
    localparam logic [24:0] CASES [8] = '{{9'h0c0, 8'h60, 8'h20}, {9'h080, 8'h20, 8'h00}, {9'h020, 8'h10, 8'h00},
        {9'h010, 8'h08, 8'h00}, {9'h004, 8'h04, 8'h00}, {9'h008, 8'h0a, 8'h08}, {9'h008, 8'h0a, 8'h02},
        {9'h100, 8'h01, 8'h00}};

    always #5 core_clk_in = ~core_clk_in;

    erqf_rx_ctrl u_erqf_rx_ctrl (.core_clk_in(core_clk_in), .rst_in(rst_in), .host_req_in(host_req),
        .host_rdata_out(host_rdata), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_stat_in(rx_stat),
        .rx_ready_out(rx_ready), .q_valid_out(q_valid), .q_byte_out(q_byte), .q_ready_in(q_ready),
        .q_drain_in(q_drain), .low_mark_in(8'h00), .irq_out(irq), .mac_ctl_word_out(mac_word),
        .heartbeat_off_out(hb_off), .forward_all_frames_out(fwd_all), .tx_enable_bit_out(tx_en),
        .rx_enable_bit_out(rx_en));

    erqf_q_sink u_erqf_q_sink (.core_clk_in(core_clk_in), .rst_in(rst_in), .q_valid_in(q_valid),
        .stall_in(stall), .q_ready_out(q_ready), .q_drain_out(q_drain));

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp_val(logic [7:0] got, logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_q(erqf_byte_t got, erqf_byte_t exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t stream got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hw(logic [9:0] a, logic [7:0] d);
        @(posedge core_clk_in) #1;
        host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_in) #1;
        host_req = '0;
    endtask

    task automatic hr(logic [9:0] a, logic [7:0] e);
        rdq.push_back(e);
        @(posedge core_clk_in) #1;
        host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_in) #1;
        host_req = '0;
    endtask

    task automatic mac_rw(logic [7:0] b, logic [7:0] d, logic [7:0] e);
        hw(OFS_MAC_WR_HI, 8'h00);
        hw(OFS_MAC_WR_LO, b);
        hw(OFS_MAC_WR_DATA, d);
        hw(OFS_MAC_RD_HI, 8'h00);
        hw(OFS_MAC_RD_LO, b);
        hr(OFS_MAC_RD_DATA, e);
    endtask

    task automatic send(int n, erqf_frame_stat_t st, bit keep, bit fin);
        erqf_byte_t b;
        for (int i = 0; i < n; i++)
        begin
            b.last = fin && (i == n - 1);
            b.data = 8'($urandom);
            if (keep)
                eq.push_back(b);
            @(posedge core_clk_in) #1;
            rx_valid = 1'b1;
            rx_byte = b;
            rx_stat = st;
        end
        @(posedge core_clk_in) #1;
        rx_valid = 1'b0;
    endtask

    task automatic wait_q;
        for (int i = 0; i < 400 && eq.size() > 0; i++)
            @(posedge core_clk_in);
        #2;
        cmp_val(8'(eq.size()), 8'h00);
    endtask

    always @(posedge core_clk_in)
        if (host_req.rd === 1'b1)
        begin
            #2;
            cmp_val(host_rdata, rdq.size() > 0 ? rdq.pop_front() : ~host_rdata);
        end

    always @(posedge core_clk_in)
        if (q_valid === 1'b1 && q_ready === 1'b1)
            cmp_q(q_byte, eq.size() > 0 ? eq.pop_front() : ~q_byte);

    // a hang ends the run as a failure rather than waiting forever
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        void'($urandom(32'h14b8));
        repeat (6) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        cmp_val({7'h0, fwd_all}, 8'h01);
        // read every byte before any write so that the reset value itself is seen
        for (int k = 0; k < 5; k++)
        begin
            hw(OFS_MAC_RD_LO, 8'(k));
            hr(OFS_MAC_RD_DATA, k < 4 ? MAC_CTL_RESET[31 - 8 * k -: 8] : 8'h00);
        end
        mac_rw(8'h04, 8'h5a, 8'h00); // beyond the word, write ignored
        mac_rw(8'h00, 8'hf7, 8'h10); // port select kept at zero
        cmp_val({7'h0, hb_off}, 8'h01);
        mac_rw(8'h01, 8'hff, 8'hbc);
        mac_rw(8'h02, 8'hff, 8'h15);
        mac_rw(8'h03, 8'hff, 8'hec);
        cmp_val({6'h0, tx_en, rx_en}, 8'h03);
        for (int k = 0; k < 4; k++)
            cmp_val(mac_word[31 - 8 * k -: 8], k == 0 ? 8'h10 : MAC_CTL_WRITABLE[31 - 8 * k -: 8]);
        v = 8'($urandom);
        hw(OFS_HIGH_MARK, v);
        hr(OFS_HIGH_MARK, v);
        v = 8'($urandom) & 8'h0f;
        hw(OFS_IRQ_ENABLES, v);
        hr(OFS_IRQ_ENABLES, v);
        hw(OFS_IRQ_ENABLES, 8'h00);
        hw(10'h3ff, 8'h5a);
        hr(10'h3ff, 8'h00);
        foreach (CASES[k])
        begin
            hw(OFS_REJECT_CTL, CASES[k][15:8]);
            hr(OFS_REJECT_CTL, CASES[k][15:8]);
            send(2 + $urandom_range(5), CASES[k][24:16], 1'b1, 1'b1);
            hw(OFS_REJECT_CTL, CASES[k][7:0]);
            send(2 + $urandom_range(5), CASES[k][24:16], 1'b0, 1'b1);
            wait_q();
        end
        hw(OFS_REJECT_CTL, 8'h00);
        send(3, 9'h006, 1'b1, 1'b1);
        send(3, 9'h005, 1'b1, 1'b1);
        wait_q();
        stall = 1'b1;
        send(34, '0, 1'b0, 1'b0);
        cmp_val({7'h0, rx_ready}, 8'h00);
        send(1, '0, 1'b0, 1'b1);
        stall = 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1;
        cmp_val({6'h0, rx_ready, irq}, 8'h02);
        hw(OFS_IRQ_ENABLES, 8'h07);
        @(posedge core_clk_in) #1;
        cmp_val({7'h0, irq}, 8'h00);
        hw(OFS_IRQ_ENABLES, 8'h08);
        @(posedge core_clk_in) #1;
        cmp_val({7'h0, irq}, 8'h01);
        hr(OFS_FLAGS, 8'h08);
        hr(OFS_FLAGS, 8'h00);
        hw(OFS_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge core_clk_in);
        #1;
        cmp_val({7'h0, irq}, 8'h00);
        wait_q();
        end_sim();
    end
endmodule // tb
